// [src/mv_regs_pkg.sv]
// Constants, field layouts and encodings for the master valid save/restore bank.
// Assumes a single core clock domain; imported whole by both ends and the interface.
package mv_regs_pkg;

    // ------------------------------------------------------------
    // Instruction field encodings
    // ------------------------------------------------------------
    localparam logic [2:0] OP1_CACHE_MV   = 3'h3;
    localparam logic [2:0] OP1_MMU_DEBUG  = 3'h5;
    localparam logic [3:0] PRI_REG_DEBUG  = 4'hf;
    localparam logic [3:0] SEC_ICACHE     = 4'h8;
    localparam logic [3:0] SEC_IAUX       = 4'ha;
    localparam logic [3:0] SEC_DCACHE     = 4'hc;
    localparam logic [3:0] SEC_DAUX       = 4'he;
    localparam logic [3:0] SEC_TLB_MV     = 4'he;
    localparam logic [3:0] SEC_UTLB_IDX   = 4'h4;
    localparam logic [2:0] OP2_DATA_IDX   = 3'h0;
    localparam logic [2:0] OP2_INSTR_IDX  = 3'h1;

    // ------------------------------------------------------------
    // Sizes, fields and reset values
    // ------------------------------------------------------------
    localparam int          MV_BITS_PER_REG = 32;
    localparam int          LINES_PER_MV    = 8;
    localparam int          MAX_MV_REGS     = 8;
    localparam int          TLB_MV_REGS     = 2;
    localparam int          IDX_LSB         = 0;
    localparam int          IDX_W           = 4;
    localparam logic [3:0]  IDX_MAX_ENTRY   = 4'ha;
    localparam logic [31:0] MV_RESET        = 32'h0;
    localparam logic [31:0] IDX_RESET       = 32'h0;

endpackage : mv_regs_pkg

// [src/mv_regs_if.sv]
// Interface joining the pipeline's coprocessor port to the register bank.
// Assumes both ends share ref_clk; one request per cycle, answer next cycle.
`timescale 1ns/1ps
`default_nettype none
interface mv_regs_if;
    import mv_regs_pkg::*;

    // Request from the pipeline
    logic        req_valid;
    logic        req_write;
    logic        req_priv;
    logic [2:0]  req_op1;
    logic [3:0]  req_pri;
    logic [3:0]  req_sec;
    logic [2:0]  req_op2;
    logic [31:0] req_wdata;
    // Answer from the bank
    logic        rsp_valid;
    logic        rsp_undef;
    logic [31:0] rsp_rdata;

    modport pipe (output req_valid, req_write, req_priv, req_op1, req_pri, req_sec,
                  req_op2, req_wdata, input rsp_valid, rsp_undef, rsp_rdata);
    modport bank (input req_valid, req_write, req_priv, req_op1, req_pri, req_sec,
                  req_op2, req_wdata, output rsp_valid, rsp_undef, rsp_rdata);
endinterface : mv_regs_if
`default_nettype wire

// [src/mv_pipe_end.sv]
// Pipeline end: turns a user-side command into one coprocessor request.
// Assumes the bank answers one cycle after each request; holds one command at a time.
`timescale 1ns/1ps
`default_nettype none
module mv_pipe_end
    import mv_regs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // User command
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic        cmd_priv,
    input  wire logic [2:0]  cmd_op1,
    input  wire logic [3:0]  cmd_pri,
    input  wire logic [3:0]  cmd_sec,
    input  wire logic [2:0]  cmd_op2,
    input  wire logic [31:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             done_valid,
    output logic             done_undef,
    output logic [31:0]      done_rdata,
    // Coprocessor port
    mv_regs_if.pipe          cp
);

    // ------------------------------------------------------------
    // Request and answer registers
    // ------------------------------------------------------------
    logic        busy_reg, busy_next;
    logic        rv_reg, rv_next, rw_reg, rw_next, rp_reg, rp_next;
    logic [2:0]  op1_reg, op1_next, op2_reg, op2_next;
    logic [3:0]  pri_reg, pri_next, sec_reg, sec_next;
    logic [31:0] wd_reg, wd_next;
    logic        dv_reg, dv_next, du_reg, du_next;
    logic [31:0] dr_reg, dr_next;

    // Next state: accept when idle, retire on the answer
    always_comb
    begin
        busy_next = busy_reg;
        rv_next   = 1'b0;
        rw_next   = rw_reg;
        rp_next   = rp_reg;
        op1_next  = op1_reg;
        op2_next  = op2_reg;
        pri_next  = pri_reg;
        sec_next  = sec_reg;
        wd_next   = wd_reg;
        dv_next   = 1'b0;
        du_next   = du_reg;
        dr_next   = dr_reg;
        if (!busy_reg && cmd_valid)
        begin
            busy_next = 1'b1;
            rv_next   = 1'b1;
            rw_next   = cmd_write;
            rp_next   = cmd_priv;
            op1_next  = cmd_op1;
            op2_next  = cmd_op2;   // Caller keeps register number in 0..7
            pri_next  = cmd_pri;
            sec_next  = cmd_sec;
            // Caller supplies only previously read words when restoring
            wd_next   = cmd_wdata;
        end
        if (cp.rsp_valid)
        begin
            busy_next = 1'b0;
            dv_next   = 1'b1;
            du_next   = cp.rsp_undef;
            dr_next   = cp.rsp_rdata;
        end
    end

    // Registering only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_reg <= 1'b0;
            rv_reg   <= 1'b0;
            rw_reg   <= 1'b0;
            rp_reg   <= 1'b0;
            op1_reg  <= 3'h0;
            op2_reg  <= 3'h0;
            pri_reg  <= 4'h0;
            sec_reg  <= 4'h0;
            wd_reg   <= 32'h0;
            dv_reg   <= 1'b0;
            du_reg   <= 1'b0;
            dr_reg   <= 32'h0;
        end
        else if (clk_en)
        begin
            busy_reg <= busy_next;
            rv_reg   <= rv_next;
            rw_reg   <= rw_next;
            rp_reg   <= rp_next;
            op1_reg  <= op1_next;
            op2_reg  <= op2_next;
            pri_reg  <= pri_next;
            sec_reg  <= sec_next;
            wd_reg   <= wd_next;
            dv_reg   <= dv_next;
            du_reg   <= du_next;
            dr_reg   <= dr_next;
        end
    end

    // Drive the port and user outputs from flops
    assign cp.req_valid = rv_reg;
    assign cp.req_write = rw_reg;
    assign cp.req_priv  = rp_reg;
    assign cp.req_op1   = op1_reg;
    assign cp.req_pri   = pri_reg;
    assign cp.req_sec   = sec_reg;
    assign cp.req_op2   = op2_reg;
    assign cp.req_wdata = wd_reg;
    assign cmd_ready    = ~busy_reg;
    assign done_valid   = dv_reg;
    assign done_undef   = du_reg;
    assign done_rdata   = dr_reg;

endmodule : mv_pipe_end
`default_nettype wire

// [src/mv_bank_end.sv]
// Register bank end: master valid words for both caches, their aux caches and
// the main TLB, plus the two micro-TLB index selects.
// Assumes the pipeline end sends at most one request per cycle on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mv_bank_end
    import mv_regs_pkg::*;
#(
    parameter int ICACHE_BYTES = 65536,
    parameter int IAUX_BYTES   = 65536,
    parameter int DCACHE_BYTES = 65536,
    parameter int DAUX_BYTES   = 65536,
    parameter int LINE_BYTES   = 32
)
(
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // Coprocessor port
    mv_regs_if.bank          cp,
    // Master valid vectors toward the valid-masking logic
    output logic [255:0]     icache_mv,
    output logic [255:0]     iaux_mv,
    output logic [255:0]     dcache_mv,
    output logic [255:0]     daux_mv,
    output logic [63:0]      tlb_mv,
    // Restore strobe for the main TLB words
    output logic             tlb_mv_written,
    // Micro-TLB entry selects, valid only when below or at ten
    output logic [3:0]       data_utlb_entry,
    output logic             data_utlb_sel_ok,
    output logic [3:0]       instr_utlb_entry,
    output logic             instr_utlb_sel_ok
);

    // ------------------------------------------------------------
    // Implemented register counts
    // ------------------------------------------------------------
    // One bit per eight lines, 32 bits per word, round up
    localparam int IC_N = (ICACHE_BYTES / (LINE_BYTES * LINES_PER_MV) + 31) / MV_BITS_PER_REG;
    localparam int IA_N = (IAUX_BYTES / (LINE_BYTES * LINES_PER_MV) + 31) / MV_BITS_PER_REG;
    localparam int DC_N = (DCACHE_BYTES / (LINE_BYTES * LINES_PER_MV) + 31) / MV_BITS_PER_REG;
    localparam int DA_N = (DAUX_BYTES / (LINE_BYTES * LINES_PER_MV) + 31) / MV_BITS_PER_REG;

    // Sizes beyond 256 bits cannot be addressed by a 3-bit register number
    if (IC_N < 1 || IC_N > MAX_MV_REGS || IA_N < 1 || IA_N > MAX_MV_REGS ||
        DC_N < 1 || DC_N > MAX_MV_REGS || DA_N < 1 || DA_N > MAX_MV_REGS)
    begin : g_size_check
        $error("mv_bank_end: cache size outside supported range");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] ic_reg [MAX_MV_REGS], ic_next [MAX_MV_REGS];
    logic [31:0] ia_reg [MAX_MV_REGS], ia_next [MAX_MV_REGS];
    logic [31:0] dc_reg [MAX_MV_REGS], dc_next [MAX_MV_REGS];
    logic [31:0] da_reg [MAX_MV_REGS], da_next [MAX_MV_REGS];
    logic [31:0] tlb_reg [TLB_MV_REGS], tlb_next [TLB_MV_REGS];
    logic [31:0] didx_reg, didx_next, iidx_reg, iidx_next;
    logic        rv_reg, rv_next, ru_reg, ru_next, tw_reg, tw_next;
    logic        dok_reg, dok_next, iok_reg, iok_next;
    logic [31:0] rd_reg, rd_next;

    // Decode terms
    logic       acc, wr, mv_grp, mmu_grp;
    logic [3:0] num;

    // Decode, read mux and write update
    always_comb
    begin
        acc     = cp.req_valid && cp.req_priv;
        wr      = acc && cp.req_write;
        mv_grp  = cp.req_op1 == OP1_CACHE_MV && cp.req_pri == PRI_REG_DEBUG;
        mmu_grp = cp.req_op1 == OP1_MMU_DEBUG && cp.req_pri == PRI_REG_DEBUG;
        num     = {1'b0, cp.req_op2};   // Register number is opcode field
        ic_next   = ic_reg;
        ia_next   = ia_reg;
        dc_next   = dc_reg;
        da_next   = da_reg;
        tlb_next  = tlb_reg;
        didx_next = didx_reg;
        iidx_next = iidx_reg;
        rv_next   = cp.req_valid;
        ru_next   = cp.req_valid && !cp.req_priv;   // User mode traps
        rd_next   = 32'h0;
        tw_next   = 1'b0;
        // Unimplemented numbers read zero, writes dropped
        if (mv_grp && cp.req_sec == SEC_ICACHE)
        begin
            if (num < IC_N)
            begin
                rd_next = ic_reg[cp.req_op2];
                if (wr)
                    ic_next[cp.req_op2] = cp.req_wdata;
            end
        end
        else if (mv_grp && cp.req_sec == SEC_IAUX)
        begin
            if (num < IA_N)
            begin
                rd_next = ia_reg[cp.req_op2];
                if (wr)
                    ia_next[cp.req_op2] = cp.req_wdata;
            end
        end
        else if (mv_grp && cp.req_sec == SEC_DCACHE)
        begin
            if (num < DC_N)
            begin
                rd_next = dc_reg[cp.req_op2];
                if (wr)
                    dc_next[cp.req_op2] = cp.req_wdata;
            end
        end
        else if (mv_grp && cp.req_sec == SEC_DAUX)
        begin
            if (num < DA_N)
            begin
                rd_next = da_reg[cp.req_op2];
                if (wr)
                    da_next[cp.req_op2] = cp.req_wdata;
            end
        end
        else if (mmu_grp && cp.req_sec == SEC_TLB_MV && num < TLB_MV_REGS)
        begin
            rd_next = tlb_reg[cp.req_op2[0]];
            if (wr)
            begin
                // Safe only while cache and TLB are off; not checked here
                tlb_next[cp.req_op2[0]] = cp.req_wdata;
                tw_next = 1'b1;
            end
        end
        else if (mmu_grp && cp.req_sec == SEC_UTLB_IDX && cp.req_op2 == OP2_DATA_IDX)
        begin
            rd_next = didx_reg;
            if (wr)
                didx_next = cp.req_wdata;   // Full word kept, low nibble used
        end
        else if (mmu_grp && cp.req_sec == SEC_UTLB_IDX && cp.req_op2 == OP2_INSTR_IDX)
        begin
            rd_next = iidx_reg;
            if (wr)
                iidx_next = cp.req_wdata;
        end
        if (!acc)
            rd_next = 32'h0;   // User or idle cycles return no data
        // Range flags kept in flops so the outputs carry no comparator
        dok_next = didx_next[IDX_LSB +: IDX_W] <= IDX_MAX_ENTRY;
        iok_next = iidx_next[IDX_LSB +: IDX_W] <= IDX_MAX_ENTRY;
    end

    // Registering only; clears all master valid words on reset
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < MAX_MV_REGS; i++)
            begin
                ic_reg[i] <= MV_RESET;
                ia_reg[i] <= MV_RESET;
                dc_reg[i] <= MV_RESET;
                da_reg[i] <= MV_RESET;
            end
            for (int j = 0; j < TLB_MV_REGS; j++)
                tlb_reg[j] <= MV_RESET;
            didx_reg <= IDX_RESET;
            iidx_reg <= IDX_RESET;
            rv_reg   <= 1'b0;
            ru_reg   <= 1'b0;
            rd_reg   <= 32'h0;
            tw_reg   <= 1'b0;
            dok_reg  <= (IDX_RESET[IDX_LSB +: IDX_W] <= IDX_MAX_ENTRY);
            iok_reg  <= (IDX_RESET[IDX_LSB +: IDX_W] <= IDX_MAX_ENTRY);
        end
        else if (clk_en)
        begin
            ic_reg   <= ic_next;
            ia_reg   <= ia_next;
            dc_reg   <= dc_next;
            da_reg   <= da_next;
            tlb_reg  <= tlb_next;
            didx_reg <= didx_next;
            iidx_reg <= iidx_next;
            rv_reg   <= rv_next;
            ru_reg   <= ru_next;
            rd_reg   <= rd_next;
            tw_reg   <= tw_next;
            dok_reg  <= dok_next;
            iok_reg  <= iok_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign cp.rsp_valid = rv_reg;
    assign cp.rsp_undef = ru_reg;
    assign cp.rsp_rdata = rd_reg;
    // Zero bit masks its eight-line group in the valid RAM
    assign icache_mv = {ic_reg[7], ic_reg[6], ic_reg[5], ic_reg[4],
                        ic_reg[3], ic_reg[2], ic_reg[1], ic_reg[0]};
    assign iaux_mv   = {ia_reg[7], ia_reg[6], ia_reg[5], ia_reg[4],
                        ia_reg[3], ia_reg[2], ia_reg[1], ia_reg[0]};
    assign dcache_mv = {dc_reg[7], dc_reg[6], dc_reg[5], dc_reg[4],
                        dc_reg[3], dc_reg[2], dc_reg[1], dc_reg[0]};
    assign daux_mv   = {da_reg[7], da_reg[6], da_reg[5], da_reg[4],
                        da_reg[3], da_reg[2], da_reg[1], da_reg[0]};
    assign tlb_mv         = {tlb_reg[1], tlb_reg[0]};
    assign tlb_mv_written = tw_reg;
    // Upper bits ignored; above ten selects nothing
    assign data_utlb_entry   = didx_reg[IDX_LSB +: IDX_W];
    assign data_utlb_sel_ok  = dok_reg;
    assign instr_utlb_entry  = iidx_reg[IDX_LSB +: IDX_W];
    assign instr_utlb_sel_ok = iok_reg;

endmodule : mv_bank_end
`default_nettype wire

// [tb/mv_regs_assertions.sv]
// Checker for the pipe/bank coprocessor interface.
// Assumes clk_en is low only while the port is idle, so every request is answered.
`timescale 1ns/1ps
`default_nettype none
module mv_regs_assertions
    import mv_regs_pkg::*;
#(
    parameter int IC_WORDS = 8
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Request side
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_priv,
    input wire logic [2:0]  req_op1,
    input wire logic [3:0]  req_pri,
    input wire logic [3:0]  req_sec,
    input wire logic [2:0]  req_op2,
    input wire logic [31:0] req_wdata,
    // Answer side
    input wire logic        rsp_valid,
    input wire logic        rsp_undef,
    input wire logic [31:0] rsp_rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // Shadow copies of three watched words
    // ----------------------------------------
    logic        pw, pr, ic_sel, tlb_sel, idx_sel;
    logic [31:0] ic0_reg, tlb1_reg, didx_reg;
    // Decode, privileged only
    assign pw      = req_valid & req_priv & req_write;
    assign pr      = req_valid & req_priv & ~req_write;
    assign ic_sel  = req_op1 == OP1_CACHE_MV && req_pri == PRI_REG_DEBUG && req_sec == SEC_ICACHE;
    assign tlb_sel = req_op1 == OP1_MMU_DEBUG && req_pri == PRI_REG_DEBUG && req_sec == SEC_TLB_MV;
    assign idx_sel = req_op1 == OP1_MMU_DEBUG && req_pri == PRI_REG_DEBUG
                     && req_sec == SEC_UTLB_IDX;
    // User writes never update, so a leaky write shows as a readback miss
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ic0_reg  <= MV_RESET;
            tlb1_reg <= MV_RESET;
            didx_reg <= IDX_RESET;
        end
        else
        begin
            if (pw && ic_sel && req_op2 == 3'h0) ic0_reg <= req_wdata;
            if (pw && tlb_sel && req_op2 == 3'h1) tlb1_reg <= req_wdata;
            if (pw && idx_sel && req_op2 == OP2_DATA_IDX) didx_reg <= req_wdata;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_answer_next: assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    a_no_stray_answer: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    a_user_undef: assert property (req_valid && !req_priv |=> rsp_undef && rsp_rdata == 32'h0)
        else $error("user access not refused");
    a_priv_defined: assert property (req_valid && req_priv |=> !rsp_undef)
        else $error("privileged access refused");
    a_icache_word: assert property (pr && ic_sel && req_op2 == 3'h0 |=> rsp_rdata == $past(ic0_reg))
        else $error("icache word 0 readback wrong");
    a_tlb_word: assert property (pr && tlb_sel && req_op2 == 3'h1 |=> rsp_rdata == $past(tlb1_reg))
        else $error("tlb word 1 readback wrong");
    a_index_word: assert property (pr && idx_sel && req_op2 == OP2_DATA_IDX |=> rsp_rdata == $past(didx_reg))
        else $error("data index readback wrong");
    a_unimpl_word: assert property (pr && ic_sel && req_op2 >= IC_WORDS |=> rsp_rdata == 32'h0)
        else $error("unimplemented word not zero");
    c_user: cover property (req_valid && !req_priv);
    c_tlb_read: cover property (pr && tlb_sel);
    c_idx_write: cover property (pw && idx_sel);
endmodule : mv_regs_assertions
`default_nettype wire

// [tb/tb_top.sv]
// Bench joining the pipe end to the bank end; drives the user side.
// Assumes one clock; expectations come from a model of the register map.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mv_regs_pkg::*;
    // Small caches, data cache at full size, so some words are unimplemented
    localparam int WB = 32 * LINES_PER_MV * MV_BITS_PER_REG;
    localparam int IC_B = 16384, IA_B = 32768, DC_B = 65536, DA_B = 8192;
    localparam int NW [6] = '{IC_B/WB, IA_B/WB, DC_B/WB, DA_B/WB, TLB_MV_REGS, 2};
    localparam logic [2:0] OP1T [6] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h5};
    localparam logic [3:0] SECT [6] = '{SEC_ICACHE, SEC_IAUX, SEC_DCACHE, SEC_DAUX,
                                        SEC_TLB_MV, SEC_UTLB_IDX};
    typedef struct { logic undef; logic [31:0] rd; bit rd_chk; } exp_s;
    logic         ref_clk, srst, clk_en, cmd_valid, cmd_write, cmd_priv;
    logic [2:0]   cmd_op1, cmd_op2;
    logic [3:0]   cmd_pri, cmd_sec, use_pri, d_ent, i_ent;
    logic [31:0]  cmd_wdata, done_rdata;
    logic         cmd_ready, done_valid, done_undef, d_ok, i_ok, tw_pulse;
    logic [255:0] mv_vec [4];
    logic [63:0]  tlb_mv;
    logic [31:0]  mdl [6][8];
    exp_s         exp_q [$];
    exp_s         e;
    int           err_count, n_compared, cyc, seed, c, o, v, n_tw, exp_tw;

    mv_regs_if cp ();
    mv_pipe_end mv_pipe_end_i (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_priv(cmd_priv), .cmd_op1(cmd_op1),
        .cmd_pri(cmd_pri), .cmd_sec(cmd_sec), .cmd_op2(cmd_op2), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .done_valid(done_valid), .done_undef(done_undef),
        .done_rdata(done_rdata), .cp(cp));
    mv_bank_end #(.ICACHE_BYTES(IC_B), .IAUX_BYTES(IA_B), .DCACHE_BYTES(DC_B),
        .DAUX_BYTES(DA_B), .LINE_BYTES(32)) mv_bank_end_i (.ref_clk(ref_clk), .srst(srst),
        .clk_en(clk_en), .cp(cp), .icache_mv(mv_vec[0]), .iaux_mv(mv_vec[1]),
        .dcache_mv(mv_vec[2]), .daux_mv(mv_vec[3]), .tlb_mv(tlb_mv), .tlb_mv_written(tw_pulse),
        .data_utlb_entry(d_ent), .data_utlb_sel_ok(d_ok), .instr_utlb_entry(i_ent),
        .instr_utlb_sel_ok(i_ok));
    mv_regs_assertions #(.IC_WORDS(NW[0])) mv_regs_assertions_i (.ref_clk(ref_clk),
        .srst(srst), .req_valid(cp.req_valid), .req_write(cp.req_write),
        .req_priv(cp.req_priv), .req_op1(cp.req_op1), .req_pri(cp.req_pri),
        .req_sec(cp.req_sec), .req_op2(cp.req_op2), .req_wdata(cp.req_wdata),
        .rsp_valid(cp.rsp_valid), .rsp_undef(cp.rsp_undef), .rsp_rdata(cp.rsp_rdata));

    // Clock at 25 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task end_sim;
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One command; the expectation is noted before it goes out
    task acc(input logic w, input logic p, input int k, input logic [2:0] op2,
             input logic [31:0] wd);
        logic hit;
        exp_s ex;   // Own copy: the answer checker reuses e while we wait
        hit = (op2 < NW[k]) && (use_pri == PRI_REG_DEBUG);
        ex.undef = !p;
        ex.rd_chk = !w;
        ex.rd = (p && hit) ? mdl[k][op2] : 32'h0;
        if (w && p && hit) mdl[k][op2] = wd;
        if (w && p && hit && k == 4) exp_tw++;   // Each TLB word write gives one strobe
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        {cmd_valid, cmd_write, cmd_priv, cmd_op1, cmd_pri} = {1'b1, w, p, OP1T[k], use_pri};
        {cmd_sec, cmd_op2, cmd_wdata} = {SECT[k], op2, wd};
        exp_q.push_back(ex);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask : acc

    // Every map slot; unimplemented words get zero, as software must
    task sweep(input logic w);
        for (c = 0; c < 6; c++)
            for (o = 0; o < 8; o++)
                acc(w, 1'b1, c, 3'(o), (o < NW[c]) ? 32'($random(seed)) : 32'h0);
        for (v = 0; v < 20 && exp_q.size() > 0; v++) @(negedge ref_clk);
    endtask : sweep

    // Outputs toward the masking logic, word n at bits 32n up
    task chk_outs;
        for (c = 0; c < 4; c++)
            for (o = 0; o < NW[c]; o++)
                check(mv_vec[c][32*o +: 32], mdl[c][o]);
        check(tlb_mv[31:0], mdl[4][0]);
        check(tlb_mv[63:32], mdl[4][1]);
        check({28'h0, d_ent, 3'h0, d_ok}, {28'h0, mdl[5][0][3:0], 3'h0, mdl[5][0][3:0] <= 4'ha});
        check({28'h0, i_ent, 3'h0, i_ok}, {28'h0, mdl[5][1][3:0], 3'h0, mdl[5][1][3:0] <= 4'ha});
    endtask : chk_outs

    // Answers are compared in arrival order
    always @(negedge ref_clk)
    begin
        if (tw_pulse === 1'b1)
            n_tw++;
        if (done_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                err_count++;
                $display("[ERR] %0t answer without command", $time);
            end
            else
            begin
                e = exp_q.pop_front();
                check({31'h0, done_undef}, {31'h0, e.undef});
                if (e.rd_chk) check(done_rdata, e.rd);
            end
        end
    end

    // Hang guard, well above the roughly 900 cycles needed
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            end_sim();
        end
    end

    initial
    begin
        seed = 32'h53e06510;
        {srst, clk_en, cmd_valid, cmd_write, cmd_priv, cmd_op1, cmd_op2} = {3'b110, 8'h0};
        {cmd_pri, cmd_sec, cmd_wdata, use_pri} = {40'h0, PRI_REG_DEBUG};
        mdl = '{default: 32'h0};
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        sweep(1'b0);
        sweep(1'b1);
        sweep(1'b0);
        chk_outs();
        // Frozen enable: a waiting command must be neither taken nor answered
        {clk_en, cmd_valid} = 2'b01;
        repeat (4) @(negedge ref_clk);
        {clk_en, cmd_valid} = 2'b10;
        chk_outs();
        for (c = 0; c < 6; c++)
        begin
            acc(1'b1, 1'b0, c, 3'h0, 32'hffff_ffff);
            acc(1'b0, 1'b0, c, 3'h0, 32'h0);
            acc(1'b0, 1'b1, c, 3'h0, 32'h0);
        end
        for (v = 0; v < 6; v++)
        begin
            acc(1'b1, 1'b1, 5, 3'(v % 2), 32'hffff_fff9 + v);
            acc(1'b0, 1'b1, 5, 3'(v % 2), 32'h0);
            repeat (4) @(negedge ref_clk);
            chk_outs();
        end
        acc(1'b1, 1'b1, 3, 3'h1, 32'ha5a5_a5a5);
        acc(1'b0, 1'b1, 3, 3'h1, 32'h0);
        acc(1'b0, 1'b1, 0, 3'h2, 32'h0);
        use_pri = 4'he;
        acc(1'b1, 1'b1, 0, 3'h0, 32'h5a5a_0f0f);
        use_pri = PRI_REG_DEBUG;
        sweep(1'b0);
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        mdl = '{default: 32'h0};
        sweep(1'b0);
        chk_outs();
        check(32'(n_tw), 32'(exp_tw));
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
